// ==== hw/llphp_fifo.sv ====
// Purpose: small first-in first-out buffer in flip-flops
// Assumes: one clock, both sides may stall
// Notes: full and empty come from an occupancy counter
`timescale 1ns/100ps
module llphp_fifo
  import llphp_pkg::*;
#(
  parameter int W     = 22,
  parameter int DEPTH = 8
)(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  // drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  // occupancy
  output logic [$clog2(DEPTH):0]          count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH-1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  // handshake terms
  assign in_ready  = (count_r != DEPTH_C);
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];
  assign count     = count_r;

  // storage write
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// ==== hw/llphp_link_request_line_ser.sv ====
// Purpose: shifts request streams out on the serial request line
// Assumes: tick marks a detected phy clock rising edge
// Notes: the line rests low while no stream is queued
`timescale 1ns/100ps
module llphp_link_request_line_ser
  import llphp_pkg::*;
(
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst,
  input  wire logic  tick,
  // stream source
  llphp_req_if.dst   req,
  // serial output
  output logic       link_request_line
);
  logic [STREAM_W-1:0] shift_r;
  logic [LEN_W-1:0]    left_r;
  logic                line_r;

  // a new stream is taken only on a phy edge with nothing in flight
  assign req.ready         = tick && (left_r == '0);
  assign link_request_line = line_r;

  // shifter, bit 0 first, one bit per phy edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= '0;
      left_r  <= '0;
      line_r  <= 1'b0;
    end
    else if (tick)
    begin
      if (left_r != '0)
      begin
        line_r  <= shift_r[0];
        shift_r <= shift_r >> 1;
        left_r  <= left_r - 1'b1;
      end
      else if (req.valid)
      begin
        line_r  <= req.stream[0];
        shift_r <= req.stream >> 1;
        left_r  <= req.len - 1'b1;
      end
      else
      begin
        line_r  <= 1'b0;
      end
    end
  end

  // first bit of every stream is a one
  start_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    (req.valid && req.ready) |=> link_request_line)
    else $error("request stream did not start with one");
  // last bit of every stream is a zero
  stop_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    (tick && left_r == 5'h01) |=> !link_request_line)
    else $error("request stream did not stop with zero");
  // the line moves only on a phy edge
  line_on_edge_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(link_request_line) |-> $past(tick))
    else $error("request line changed away from a phy edge");
endmodule

// ==== hw/llphp_pkg.sv ====
// Purpose: shared constants for the link-layer phy and host port
// Assumes: core_clk at 10 MHz samples the phy pins and host select and write through three flip-flops
// Notes: host register indices and request word layout are local choices
package llphp_pkg;
  // control pair width is fixed for every data width
  localparam int          CTL_W        = 2;
  localparam logic [1:0]  PHY_IDLE     = 2'h0;
  localparam logic [1:0]  PHY_STATUS   = 2'h1;
  localparam logic [1:0]  PHY_RECEIVE  = 2'h2;
  localparam logic [1:0]  PHY_GRANT    = 2'h3;
  localparam logic [1:0]  LNK_RELEASE  = 2'h0;
  localparam logic [1:0]  LNK_HOLD     = 2'h1;
  localparam logic [1:0]  LNK_TRANSMIT = 2'h2;
  localparam logic [1:0]  LNK_UNUSED   = 2'h3;
  // request stream lengths and types
  localparam int          STREAM_W     = 17;
  localparam int          LEN_W        = 5;
  localparam logic [4:0]  LEN_BUS      = 5'h07;
  localparam logic [4:0]  LEN_READ     = 5'h09;
  localparam logic [4:0]  LEN_WRITE    = 5'h11;
  localparam logic [2:0]  TYPE_RDREG   = 3'h4;
  localparam logic [2:0]  TYPE_WRREG   = 3'h5;
  // request stream field positions, bit 0 is the start bit
  localparam int          ST_TYPE_LO   = 1;
  localparam int          ST_SPEED_LO  = 4;
  localparam int          ST_ADDR_LO   = 4;
  localparam int          ST_DATA_LO   = 8;
  // status word field positions
  localparam int          SR_COUNT_LO  = 8;
  localparam int          SR_TXPEND    = 16;
  localparam int          SR_RXNEW     = 17;
  // host word fields for a request write
  localparam int          HW_TYPE_LO   = 0;
  localparam int          HW_SPEED_LO  = 3;
  localparam int          HW_ADDR_LO   = 5;
  localparam int          HW_WDATA_LO  = 9;
  // host register indices
  localparam logic [7:0]  IDX_REQUEST  = 8'h00;
  localparam logic [7:0]  IDX_TX_DATA  = 8'h01;
  localparam logic [7:0]  IDX_RX_DATA  = 8'h02;
  localparam logic [7:0]  IDX_STATUS   = 8'h03;
  // acknowledge latency bound in local clocks
  localparam int          ACK_MAX_CYC  = 9;
endpackage

// ==== hw/llphp_req_if.sv ====
// Purpose: carries one request stream from the queue to the serialiser
// Assumes: valid/ready handshake on core_clk
// Notes: stream bit 0 is sent first
`timescale 1ns/100ps
interface llphp_req_if;
  import llphp_pkg::*;
  logic                valid;
  logic                ready;
  logic [STREAM_W-1:0] stream;
  logic [LEN_W-1:0]    len;
  modport src (output valid, output stream, output len, input ready);
  modport dst (input valid, input stream, input len, output ready);
endinterface

// ==== hw/llphp_top.sv ====
// Purpose: host port and phy-link port of a serial-bus link layer
// Assumes: host and phy pins are asynchronous to core_clk
// Notes: phy pins and host select and write pass three flops; a change counts when stages two and three agree
`timescale 1ns/100ps
module llphp_top
  import llphp_pkg::*;
#(
  parameter int DATA_W     = 8,
  parameter int FIFO_DEPTH = 8
)(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // host port
  input  wire logic              host_cs_n,
  input  wire logic              host_wr_n,
  input  wire logic [7:0]        host_register_index,
  input  wire logic [31:0]       host_data_word_in,
  output logic      [31:0]       host_data_word_out,
  output logic                   host_data_word_oe,
  output logic                   host_access_done_n,
  // phy-link port
  input  wire logic              phy_clk,
  input  wire logic [DATA_W-1:0] phy_data_lines_in,
  output logic      [DATA_W-1:0] phy_data_lines_out,
  output logic                   phy_data_lines_oe,
  input  wire logic [CTL_W-1:0]  phy_control_pair_in,
  output logic      [CTL_W-1:0]  phy_control_pair_out,
  output logic                   phy_control_pair_oe,
  output logic                   link_request_line
);
  localparam int PW = 3 + CTL_W + DATA_W;
  localparam int QW = STREAM_W + LEN_W;
  localparam int PCLK = PW - 1;
  localparam int PCS  = PW - 2;
  localparam int PWR  = PW - 3;
  localparam logic [PW-1:0] PIN_RST = {1'b0, 1'b1, 1'b1, {(CTL_W + DATA_W){1'b0}}};
  localparam logic [3:0] ACK_MAX_C = 4'(ACK_MAX_CYC);

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_ACT  = 3'h2,
    H_DONE = 3'h4
  } llphp_host_type;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_HOLD = 4'h2,
    TX_SEND = 4'h4,
    TX_END  = 4'h8
  } llphp_tx_type;

  logic [PW-1:0]         s1_r;
  logic [PW-1:0]         s2_r;
  logic [PW-1:0]         s3_r;
  logic [PW-1:0]         stab_r;
  logic [PW-1:0]         stab_nxt;
  logic                  clk_prev_r;
  logic                  phy_tick;
  logic [CTL_W-1:0]      ctl_s;
  logic [DATA_W-1:0]     data_s;
  llphp_host_type        h_state_r;
  llphp_tx_type          tx_state_r;
  logic                  is_write;
  logic                  q_in_valid;
  logic                  q_in_ready;
  logic [QW-1:0]         q_in_data;
  logic [QW-1:0]         q_out_data;
  logic [$clog2(FIFO_DEPTH):0] q_count;
  logic [STREAM_W-1:0]   stream_nxt;
  logic [LEN_W-1:0]      len_nxt;
  logic [DATA_W-1:0]     tx_data_r;
  logic                  tx_pend_r;
  logic [DATA_W-1:0]     rx_data_r;
  logic [DATA_W-1:0]     phy_stat_r;
  logic                  rx_new_r;
  logic [31:0]           rd_word;
  logic [3:0]            ack_wait_r;

  llphp_req_if req_if ();

  // three-stage pin synchronisers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
    end
    else
    begin
      s1_r <= {phy_clk, host_cs_n, host_wr_n, phy_control_pair_in, phy_data_lines_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit takes a new value once stages two and three agree
  assign stab_nxt = (s2_r & ~(s2_r ^ s3_r)) | (stab_r & (s2_r ^ s3_r));

  // agreed pin values and phy clock edge history
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      stab_r     <= PIN_RST;
      clk_prev_r <= 1'b0;
    end
    else
    begin
      stab_r     <= stab_nxt;
      clk_prev_r <= stab_r[PCLK];
    end
  end

  // phy clock rising edge and sampled phy inputs
  assign phy_tick = stab_r[PCLK] && !clk_prev_r;
  assign ctl_s    = stab_r[DATA_W +: CTL_W];
  assign data_s   = stab_r[DATA_W-1:0];
  assign is_write = !stab_r[PWR];

  // host access sequence, acknowledge only after synchronised select
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      h_state_r <= H_IDLE;
    end
    else
    begin
      case (h_state_r)
        H_IDLE:
        begin
          if (!stab_r[PCS])
          begin
            h_state_r <= H_ACT;
          end
        end
        H_ACT:
        begin
          // a request write waits for room in the queue
          if (!(is_write && host_register_index == IDX_REQUEST) || q_in_ready)
          begin
            h_state_r <= H_DONE;
          end
        end
        H_DONE:
        begin
          if (stab_r[PCS])
          begin
            h_state_r <= H_IDLE;
          end
        end
        default:
        begin
          h_state_r <= H_IDLE;
        end
      endcase
    end
  end

  // acknowledge and read data from flops; inputs are held by the host
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      host_access_done_n <= 1'b1;
      host_data_word_out <= '0;
      host_data_word_oe  <= 1'b0;
    end
    else
    begin
      host_access_done_n <= !(h_state_r == H_ACT && h_state_nxt_done()) &&
                            !(h_state_r == H_DONE && !stab_r[PCS]);
      if (h_state_r == H_ACT && !is_write)
      begin
        host_data_word_out <= rd_word;
        host_data_word_oe  <= 1'b1;
      end
      else if (h_state_r != H_DONE || stab_r[PCS])
      begin
        host_data_word_oe  <= 1'b0;
      end
    end
  end

  // true when the access leaves the active state this cycle
  function automatic logic h_state_nxt_done();
    h_state_nxt_done = !(is_write && host_register_index == IDX_REQUEST) || q_in_ready;
  endfunction

  // read multiplexer
  always_comb
  begin
    rd_word = '0;
    if (host_register_index == IDX_TX_DATA)
    begin
      rd_word[DATA_W-1:0] = tx_data_r;
    end
    else if (host_register_index == IDX_RX_DATA)
    begin
      rd_word[DATA_W-1:0] = rx_data_r;
    end
    else if (host_register_index == IDX_STATUS)
    begin
      rd_word[DATA_W-1:0] = phy_stat_r;
      rd_word[SR_COUNT_LO +: $clog2(FIFO_DEPTH)+1] = q_count;
      rd_word[SR_TXPEND] = tx_pend_r;
      rd_word[SR_RXNEW] = rx_new_r;
    end
  end

  // build the request stream from the host word
  always_comb
  begin
    stream_nxt    = '0;
    stream_nxt[0] = 1'b1;
    stream_nxt[ST_TYPE_LO +: 3] = host_data_word_in[HW_TYPE_LO +: 3];
    if (host_data_word_in[HW_TYPE_LO +: 3] == TYPE_WRREG)
    begin
      stream_nxt[ST_ADDR_LO +: 4] = host_data_word_in[HW_ADDR_LO +: 4];
      stream_nxt[ST_DATA_LO +: 8] = host_data_word_in[HW_WDATA_LO +: 8];
      len_nxt = LEN_WRITE;
    end
    else if (host_data_word_in[HW_TYPE_LO +: 3] == TYPE_RDREG)
    begin
      stream_nxt[ST_ADDR_LO +: 4] = host_data_word_in[HW_ADDR_LO +: 4];
      len_nxt = LEN_READ;
    end
    else
    begin
      stream_nxt[ST_SPEED_LO +: 2] = host_data_word_in[HW_SPEED_LO +: 2];
      len_nxt = LEN_BUS;
    end
  end

  // queue a request while a request write is active
  assign q_in_valid = (h_state_r == H_ACT) && is_write && (host_register_index == IDX_REQUEST);
  assign q_in_data  = {len_nxt, stream_nxt};

  llphp_fifo #(
    .W     (QW),
    .DEPTH (FIFO_DEPTH)
  ) i_llphp_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (q_in_valid),
    .in_ready  (q_in_ready),
    .in_data   (q_in_data),
    .out_valid (req_if.valid),
    .out_ready (req_if.ready),
    .out_data  (q_out_data),
    .count     (q_count)
  );

  assign req_if.stream = q_out_data[STREAM_W-1:0];
  assign req_if.len    = q_out_data[QW-1:STREAM_W];

  llphp_link_request_line_ser i_llphp_link_request_line_ser (
    .core_clk          (core_clk),
    .rst               (rst),
    .tick              (phy_tick),
    .req               (req_if),
    .link_request_line (link_request_line)
  );

  // link transmit sequence: hold, transmit if a byte is pending, release, then let go of the lines
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_r           <= TX_IDLE;
      phy_control_pair_out <= LNK_RELEASE;
      phy_data_lines_out   <= '0;
      phy_control_pair_oe  <= 1'b0;
      phy_data_lines_oe    <= 1'b0;
    end
    else if (phy_tick)
    begin
      case (tx_state_r)
        TX_IDLE:
        begin
          if (ctl_s == PHY_GRANT)
          begin
            tx_state_r           <= TX_HOLD;
            phy_control_pair_out <= LNK_HOLD;
            phy_control_pair_oe  <= 1'b1;
            phy_data_lines_oe    <= 1'b1;
          end
        end
        TX_HOLD:
        begin
          tx_state_r           <= tx_pend_r ? TX_SEND : TX_END;
          phy_control_pair_out <= tx_pend_r ? LNK_TRANSMIT : LNK_RELEASE;
          phy_data_lines_out   <= tx_pend_r ? tx_data_r : '0;
        end
        TX_SEND:
        begin
          tx_state_r           <= TX_END;
          phy_control_pair_out <= LNK_RELEASE;
          phy_data_lines_out   <= '0;
        end
        TX_END:
        begin
          tx_state_r           <= TX_IDLE;
          phy_control_pair_oe  <= 1'b0;
          phy_data_lines_oe    <= 1'b0;
        end
        default:
        begin
          tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // host-loaded transmit byte; set by the host, cleared when sent
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_data_r <= '0;
      tx_pend_r <= 1'b0;
    end
    else if (h_state_r == H_ACT && is_write && host_register_index == IDX_TX_DATA)
    begin
      tx_data_r <= host_data_word_in[DATA_W-1:0];
      tx_pend_r <= 1'b1;
    end
    else if (phy_tick && tx_state_r == TX_HOLD)
    begin
      tx_pend_r <= 1'b0;
    end
  end

  // receive and status capture from the phy; new data wins over a host clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_data_r  <= '0;
      phy_stat_r <= '0;
      rx_new_r   <= 1'b0;
    end
    else
    begin
      if (phy_tick && tx_state_r == TX_IDLE && ctl_s == PHY_RECEIVE)
      begin
        rx_data_r <= data_s;
        rx_new_r  <= 1'b1;
      end
      else if (h_state_r == H_ACT && !is_write && host_register_index == IDX_RX_DATA)
      begin
        rx_new_r  <= 1'b0;
      end
      if (phy_tick && tx_state_r == TX_IDLE && ctl_s == PHY_STATUS)
      begin
        phy_stat_r <= data_s;
      end
    end
  end

  // cycles spent waiting for acknowledge after select is seen low
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_wait_r <= '0;
    end
    else if (h_state_r == H_ACT)
    begin
      ack_wait_r <= ack_wait_r + 1'b1;
    end
    else
    begin
      ack_wait_r <= '0;
    end
  end

  data_width_a: assert property (@(posedge core_clk) disable iff (rst)
    (DATA_W == 2 || DATA_W == 4 || DATA_W == 8))
    else $error("phy data width must be 2, 4 or 8");
  ack_bound_a: assert property (@(posedge core_clk) disable iff (rst)
    ($fell(stab_r[PCS]) && q_in_ready) |-> ##[1:9] !host_access_done_n)
    else $error("acknowledge late after select");
  ack_wait_a: assert property (@(posedge core_clk) disable iff (rst)
    (h_state_r == H_ACT && ack_wait_r > ACK_MAX_C) |-> $past(!q_in_ready))
    else $error("access held without back-pressure");
  ack_synced_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(host_access_done_n) |-> $past(!stab_r[PCS], 2))
    else $error("acknowledge before synchronised select");
  drive_grant_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(phy_control_pair_oe) |-> $past(phy_tick && ctl_s == PHY_GRANT))
    else $error("link drove control without a grant");
  no_unused_a: assert property (@(posedge core_clk) disable iff (rst)
    phy_control_pair_oe |-> (phy_control_pair_out != LNK_UNUSED))
    else $error("link drove the unused control code");
  send_code_a: assert property (@(posedge core_clk) disable iff (rst)
    (tx_state_r == TX_SEND) |-> (phy_control_pair_out == LNK_TRANSMIT))
    else $error("transmit state without transmit code");
  reset_quiet_a: assert property (@(posedge core_clk)
    $fell(rst) |-> (!phy_control_pair_oe && !phy_data_lines_oe && !link_request_line))
    else $error("phy lines active at reset release");
endmodule

// ==== tb/link_layer_phy_and_host_port_bench.sv ====
// Purpose: self-checking bench for the link-layer phy and host port
// Assumes: host pins change at falling edges of core_clk
// Notes: shared host data is resolved from both drivers' enables
`timescale 1ns/100ps
module link_layer_phy_and_host_port_bench
  import llphp_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        host_cs_n = 1'b1;
  logic        host_wr_n = 1'b1;
  logic [7:0]  host_register_index = 8'h00;
  logic [31:0] hdrv = 32'h0;
  logic        hd_en = 1'b0;
  logic [31:0] host_data_word_in, host_data_word_out;
  logic        host_data_word_oe, host_access_done_n, phy_clk, link_request_line;
  logic [7:0]  pd_in, pd_out;
  logic [1:0]  pc_in, pc_out;
  logic        pd_oe, pc_oe;
  logic [31:0] q, w[24];
  int          mismatches = 0;
  int          checks_done = 0;
  int          lat, n;
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  // host data bus: link, host, or inverse of last host value when free
  assign host_data_word_in = host_data_word_oe ? host_data_word_out : (hd_en ? hdrv : ~hdrv);
  // design and phy partner
  llphp_top #(.DATA_W(8), .FIFO_DEPTH(8)) i_llphp_top (
    .core_clk(core_clk), .rst(rst), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
    .host_register_index(host_register_index), .host_data_word_in(host_data_word_in),
    .host_data_word_out(host_data_word_out), .host_data_word_oe(host_data_word_oe),
    .host_access_done_n(host_access_done_n), .phy_clk(phy_clk),
    .phy_data_lines_in(pd_in), .phy_data_lines_out(pd_out), .phy_data_lines_oe(pd_oe),
    .phy_control_pair_in(pc_in), .phy_control_pair_out(pc_out),
    .phy_control_pair_oe(pc_oe), .link_request_line(link_request_line));
  llphp_phy_model #(.DATA_W(8)) i_llphp_phy_model (
    .ctl_out(pc_out), .ctl_oe(pc_oe), .dat_out(pd_out), .dat_oe(pd_oe),
    .link_request_line(link_request_line), .phy_clk(phy_clk), .ctl_wire(pc_in),
    .dat_wire(pd_in));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one host access; request held until acknowledge is seen low
  task automatic host(input logic wr, input logic [7:0] ix, input logic [31:0] d);
    @(negedge core_clk);
    host_cs_n = 1'b0;
    host_wr_n = ~wr;
    host_register_index = ix;
    hdrv = d;
    hd_en = wr;
    lat = 0;
    while (host_access_done_n !== 1'b0 && lat < 400)
    begin
      @(negedge core_clk);
      lat++;
    end
    chk(host_access_done_n, 1'b0);
    q = host_data_word_out;
    if (!wr)
      chk(host_data_word_oe, 1'b1);
    host_cs_n = 1'b1;
    hd_en = 1'b0;
    for (int i = 0; i < 20 && host_access_done_n !== 1'b1; i++)
      @(negedge core_clk);
    chk(host_access_done_n, 1'b1);
  endtask
  // expected request stream from a host request word
  function automatic logic [16:0] exp_s(input logic [31:0] v);
    if (v[2:0] == TYPE_WRREG)
      return {1'b0, v[16:9], v[8:5], v[2:0], 1'b1};
    if (v[2:0] == TYPE_RDREG)
      return {8'h00, v[8:5], v[2:0], 1'b1};
    return {10'h000, v[4:3], v[2:0], 1'b1};
  endfunction
  // outputs released and request line low after reset
  task automatic t_reset();
    chk({pd_oe, pc_oe, host_data_word_oe, link_request_line}, 4'h0);
    chk(host_access_done_n, 1'b1);
  endtask
  // back-to-back write then reads, acknowledge bound, unknown index
  task automatic t_host();
    host(1'b1, IDX_TX_DATA, 32'h0000_00a5);
    chk(lat <= ACK_MAX_CYC, 1'b1);
    host(1'b0, IDX_TX_DATA, 32'h0);
    chk(lat <= ACK_MAX_CYC, 1'b1);
    chk(q[7:0], 8'ha5);
    host(1'b0, 8'h7f, 32'h0);
    chk(q, 32'h0);
  endtask
  // grant: hold, transmit with pending byte, release, then lines free again
  task automatic t_grant();
    chk(pc_oe | pd_oe, 1'b0);
    i_llphp_phy_model.grant();
    chk(32'(i_llphp_phy_model.codes.size()), 32'd3);
    chk({i_llphp_phy_model.codes[0], i_llphp_phy_model.codes[1]}, 4'h6);
    chk(i_llphp_phy_model.codes[2], LNK_RELEASE);
    chk(i_llphp_phy_model.tx_seen[0], 8'ha5);
    chk(pc_oe | pd_oe, 1'b0);
  endtask
  // status and receive transfers captured on phy clock edges
  task automatic t_rx();
    i_llphp_phy_model.send(PHY_STATUS, 8'h3c);
    host(1'b0, IDX_STATUS, 32'h0);
    chk(q[7:0], 8'h3c);
    i_llphp_phy_model.send(PHY_RECEIVE, 8'hc3);
    host(1'b0, IDX_STATUS, 32'h0);
    chk(q[17], 1'b1);
    host(1'b0, IDX_RX_DATA, 32'h0);
    chk(q[7:0], 8'hc3);
    host(1'b0, IDX_STATUS, 32'h0);
    chk(q[17:16], 2'h0);
    chk(pc_oe, 1'b0);
  endtask
  // request words of every type until the queue refuses, then drain and compare
  task automatic t_req();
    n = 0;
    lat = 0;
    while (n < 24 && lat <= ACK_MAX_CYC)
    begin
      w[n] = {15'h0, 8'(n * 17 + 3), 4'(n), 2'(n), 3'(n % 6)};
      host(1'b1, IDX_REQUEST, w[n]);
      n++;
    end
    chk(lat > ACK_MAX_CYC, 1'b1);
    host(1'b0, IDX_STATUS, 32'h0);
    chk(q[11:8], 4'h8);
    for (int i = 0; i < 6000 && i_llphp_phy_model.streams.size() < n; i++)
      @(negedge core_clk);
    chk(32'(i_llphp_phy_model.streams.size()), 32'(n));
    for (int i = 0; i < n; i++)
      chk(i_llphp_phy_model.streams[i], exp_s(w[i]));
    repeat (10) @(negedge core_clk);
    chk(link_request_line, 1'b0);
    host(1'b0, IDX_STATUS, 32'h0);
    chk(q[11:8], 4'h0);
  endtask
  // counts and verdict
  task automatic wrap_up();
    $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #3000000;
    mismatches++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_reset();
    t_host();
    t_grant();
    t_rx();
    t_req();
    wrap_up();
  end
endmodule

// ==== tb/llphp_phy_model.sv ====
// Purpose: phy-side partner: free clock, control and data lines, request capture
// Assumes: the phy changes its lines 5 ns after its clock rises
// Notes: a line nobody drives shows the inverse of its last phy value
`timescale 1ns/100ps
module llphp_phy_model
  import llphp_pkg::*;
#(
  parameter int DATA_W = 8
)(
  // link side outputs
  input  wire logic [1:0]        ctl_out,
  input  wire logic              ctl_oe,
  input  wire logic [DATA_W-1:0] dat_out,
  input  wire logic              dat_oe,
  input  wire logic              link_request_line,
  // resolved lines
  output logic                   phy_clk,
  output logic [1:0]             ctl_wire,
  output logic [DATA_W-1:0]      dat_wire
);
  logic [1:0]        ctl_r = 2'h0;
  logic              ctl_en = 1'b1;
  logic [DATA_W-1:0] dat_r = '0;
  logic              dat_en = 1'b0;
  logic [16:0]       sh = 17'h0;
  int                nb = 0;
  logic [16:0]       streams[$];
  logic [1:0]        codes[$];
  logic [DATA_W-1:0] tx_seen[$];
  // phy clock runs free at 800 ns
  initial phy_clk = 1'b0;
  always #400 phy_clk = ~phy_clk;
  // the phy owns the lines and hands them over only by a grant
  assign ctl_wire = ctl_oe ? ctl_out : (ctl_en ? ctl_r : ~ctl_r);
  assign dat_wire = dat_oe ? dat_out : (dat_en ? dat_r : ~dat_r);
  // gather request bits; the type field sets the length
  always @(posedge phy_clk)
  begin
    if (ctl_oe === 1'b1)
    begin
      codes.push_back(ctl_out);
      if (ctl_out === LNK_TRANSMIT)
        tx_seen.push_back(dat_oe ? dat_out : 'x);
    end
    if (nb == 0 && link_request_line === 1'b1)
    begin
      sh = 17'h1;
      nb = 1;
    end
    else if (nb > 0)
    begin
      sh[nb] = link_request_line;
      nb++;
      if (nb == ((sh[3:1] == TYPE_WRREG) ? 17 : (sh[3:1] == TYPE_RDREG) ? 9 : 7))
      begin
        streams.push_back(sh);
        nb = 0;
      end
    end
  end
  // one phy clock of status or receive with data
  task automatic send(input logic [1:0] code, input logic [DATA_W-1:0] d);
    @(posedge phy_clk);
    #5 ctl_r = code;
    dat_r = d;
    dat_en = 1'b1;
    @(posedge phy_clk);
    #5 ctl_r = PHY_IDLE;
    dat_en = 1'b0;
  endtask
  // grant for one phy clock, release, take the lines back once the link is done
  task automatic grant();
    @(posedge phy_clk);
    #5 ctl_r = PHY_GRANT;
    @(posedge phy_clk);
    #5 ctl_en = 1'b0;
    repeat (8) @(posedge phy_clk);
    #5 ctl_r = PHY_IDLE;
    ctl_en = 1'b1;
  endtask
endmodule
